// ---- logic/bst_params.svh ----
// Constants for the boundary-scan test access port
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
`define BST_IR_W 4
`define BST_IR_CAPTURE 4'h1
`define BST_IR_RESET 4'h2
`define BST_OP_BYPASS 4'hf
`define BST_OP_IDCODE 4'h2
`define BST_ID_W 32
`define BST_ID_VALUE 32'h0000_1001
`define BST_DATA_W 36
// Earlier TMS samples kept; with the current one they make the five-high reset run
`define BST_TLR_HIST_W 4
`endif

// ---- logic/bst_pkg.sv ----
// Types for the boundary-scan test access port
`default_nettype none
package bst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bst_state_t;
  typedef struct packed {
    logic tms;
    logic tdi;
  } bst_pins_t;
endpackage
`default_nettype wire

// ---- logic/bst_tap.sv ----
// Boundary-scan TAP controller with FIFO data output gating
//
// Function
// - All test logic runs on the test clock, separate from the FIFO clocks.
// - TMS and TDI are sampled on rising test clock edges.
// - TDI shifts into the selected instruction, identification or bypass register.
// - TDO changes on falling test clock edges from the selected register.
// - TDO is driven only in Shift-DR and Shift-IR.
// - The state machine moves on the TMS value sampled at each rising edge.
// - Test reset low puts the controller into Test-Logic-Reset at once.
// - No power-up reset; test reset or five TMS-high clocks are required.
// - FIFO data outputs stay off until the controller has been reset.
// - Master reset clears the data output register to zero.
`include "bst_params.svh"
`default_nettype none
module bst_tap (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Core reset, active low
  input wire logic tck, // Test clock
  input wire logic tms, // Test mode select
  input wire logic tdi, // Test data in
  input wire logic trst_n, // Test reset, active low
  input wire logic master_reset_n, // FIFO master reset, active low
  input wire logic oe_n, // FIFO output enable, active low
  input wire logic [`BST_DATA_W-1:0] fifo_q, // FIFO output register data
  output logic tdo, // Test data out
  output logic tdo_oe, // Test data out enable
  output logic [`BST_DATA_W-1:0] q_out, // Data outputs
  output logic q_oe, // Data output enable
  output logic tap_reset_seen // Controller has been reset
);

  // ----------------------------------------
  // Core reset synchroniser
  // ----------------------------------------
  logic rst_s1_ff, rst_s2_ff, nxt_rst_s1, nxt_rst_s2;
  always_comb
  begin
    nxt_rst_s1 = 1'b1;
    nxt_rst_s2 = rst_s1_ff;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= nxt_rst_s1;
      rst_s2_ff <= nxt_rst_s2;
    end
  end

  // ----------------------------------------
  // TAP state machine (test clock domain)
  // ----------------------------------------
  bst_pkg::bst_state_t st_ff, nxt_st;
  bst_pkg::bst_pins_t pins;
  logic [`BST_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic [`BST_ID_W-1:0] id_ff, nxt_id;
  logic byp_ff, nxt_byp;
  logic rst_seen_ff, nxt_rst_seen;
  // TMS history: five highs force Test-Logic-Reset even from an unknown power-up state
  logic [`BST_TLR_HIST_W-1:0] tms_hist_ff, nxt_tms_hist;

  assign pins = '{tms: tms, tdi: tdi};

  function automatic bst_pkg::bst_state_t step(bst_pkg::bst_state_t s, logic m);
    unique case (s)
      bst_pkg::TLR: step = m ? bst_pkg::TLR : bst_pkg::RTI;
      bst_pkg::RTI: step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_DR: step = m ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
      bst_pkg::CAP_DR: step = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::SH_DR: step = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::EX1_DR: step = m ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
      bst_pkg::PAU_DR: step = m ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
      bst_pkg::EX2_DR: step = m ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
      bst_pkg::UPD_DR: step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_IR: step = m ? bst_pkg::TLR : bst_pkg::CAP_IR;
      bst_pkg::CAP_IR: step = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::SH_IR: step = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::EX1_IR: step = m ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
      bst_pkg::PAU_IR: step = m ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
      bst_pkg::EX2_IR: step = m ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
      bst_pkg::UPD_IR: step = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
    endcase
  endfunction

  always_comb
  begin
    nxt_tms_hist = {tms_hist_ff[`BST_TLR_HIST_W-2:0], pins.tms};
    if (&{tms_hist_ff, pins.tms})
      nxt_st = bst_pkg::TLR;
    else
      nxt_st = step(st_ff, pins.tms);
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_id = id_ff;
    nxt_byp = byp_ff;
    nxt_rst_seen = rst_seen_ff;
    unique case (st_ff)
      bst_pkg::TLR:
      begin
        nxt_ir = `BST_IR_RESET;
        nxt_rst_seen = 1'b1;
      end
      bst_pkg::CAP_IR: nxt_ir_sh = `BST_IR_CAPTURE;
      bst_pkg::SH_IR: nxt_ir_sh = {pins.tdi, ir_sh_ff[`BST_IR_W-1:1]};
      bst_pkg::UPD_IR: nxt_ir = ir_sh_ff;
      bst_pkg::CAP_DR:
      begin
        nxt_id = `BST_ID_VALUE;
        nxt_byp = 1'b0;
      end
      bst_pkg::SH_DR:
      begin
        if (ir_ff == `BST_OP_IDCODE)
          nxt_id = {pins.tdi, id_ff[`BST_ID_W-1:1]};
        else
          nxt_byp = pins.tdi;
      end
      default: ;
    endcase
  end

  // Five TMS-high clocks reach TLR from any state through the TMS history check
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      st_ff <= bst_pkg::TLR;
      ir_sh_ff <= '0;
      ir_ff <= `BST_IR_RESET;
      id_ff <= '0;
      byp_ff <= 1'b0;
      rst_seen_ff <= 1'b1;
      tms_hist_ff <= '0;
    end
    else
    begin
      tms_hist_ff <= nxt_tms_hist;
      st_ff <= nxt_st;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      id_ff <= nxt_id;
      byp_ff <= nxt_byp;
      rst_seen_ff <= nxt_rst_seen;
    end
  end

  // ----------------------------------------
  // TDO on falling test clock
  // ----------------------------------------
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
  always_comb
  begin
    nxt_tdo_oe = (st_ff == bst_pkg::SH_DR) || (st_ff == bst_pkg::SH_IR);
    if (st_ff == bst_pkg::SH_IR)
      nxt_tdo = ir_sh_ff[0];
    else if (ir_ff == `BST_OP_IDCODE)
      nxt_tdo = id_ff[0];
    else
      nxt_tdo = byp_ff;
  end

  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else
    begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end
  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ----------------------------------------
  // Core domain: data output gating
  // ----------------------------------------
  // Level crossing; the reset-seen flag is quasi-static once set
  logic seen_s1_ff, seen_s2_ff, oe_s1_ff, oe_s2_ff, mr_s1_ff, mr_s2_ff;
  logic [`BST_DATA_W-1:0] q_ff, nxt_q;
  logic q_oe_ff, nxt_q_oe, seen_o_ff;
  always_comb
  begin
    // Master reset clears the presented output register
    nxt_q = mr_s2_ff ? fifo_q : '0;
    nxt_q_oe = seen_s2_ff && !oe_s2_ff;
  end

  always_ff @(posedge core_clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      seen_s1_ff <= 1'b0;
      seen_s2_ff <= 1'b0;
      oe_s1_ff <= 1'b1;
      oe_s2_ff <= 1'b1;
      mr_s1_ff <= 1'b0;
      mr_s2_ff <= 1'b0;
      q_ff <= '0;
      q_oe_ff <= 1'b0;
      seen_o_ff <= 1'b0;
    end
    else
    begin
      seen_s1_ff <= rst_seen_ff;
      seen_s2_ff <= seen_s1_ff;
      oe_s1_ff <= oe_n;
      oe_s2_ff <= oe_s1_ff;
      mr_s1_ff <= master_reset_n;
      mr_s2_ff <= mr_s1_ff;
      q_ff <= nxt_q;
      q_oe_ff <= nxt_q_oe;
      seen_o_ff <= seen_s2_ff;
    end
  end
  assign q_out = q_ff;
  assign q_oe = q_oe_ff;
  assign tap_reset_seen = seen_o_ff;

endmodule
`default_nettype wire

// ---- verif/bst_tap_sva.sv ----
// Assertions on the scan port outputs
`include "bst_params.svh"
`default_nettype none
module bst_tap_sva (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // core reset
  input wire logic tck, // test clock
  input wire logic tms, // mode select
  input wire logic trst_n, // test reset
  input wire logic master_reset_n, // fifo reset
  input wire logic oe_n, // output enable
  input wire logic tdo, // test data
  input wire logic tdo_oe, // its enable
  input wire logic [`BST_DATA_W-1:0] q_out, // data out
  input wire logic q_oe, // data enable
  input wire logic tap_reset_seen // tap reset
);
  timeunit 1ns;
  timeprecision 1ps;
  a_trst_async:
    assert property (@(posedge core_clk) disable iff (!rst_n) !trst_n |-> !tdo_oe)
    else $error("tdo on in reset");
  a_tms_reset:
    assert property (@(posedge tck) disable iff (!trst_n) tms[*5] |=> !tdo_oe)
    else $error("no reset by tms");
  a_shift_entry:
    assert property (@(posedge tck) disable iff (!trst_n)
      tms[*5] ##1 !tms ##1 tms ##1 !tms[*2] |=> tdo_oe) else $error("no shift");
  a_shift_exit:
    assert property (@(posedge tck) disable iff (!trst_n) tdo_oe && tms |=> !tdo_oe)
    else $error("tdo on after shift");
  a_tdo_falls:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe)) else $error("tdo moved");
  a_q_gated:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      q_oe |-> tap_reset_seen && !$past(oe_n, 3)) else $error("q on early");
  a_oe_off:
    assert property (@(posedge core_clk) disable iff (!rst_n) oe_n[*4] |-> !q_oe)
    else $error("q on");
  a_mr_clears:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !master_reset_n[*4] |-> q_out == '0) else $error("q not cleared");
endmodule
bind bst_tap bst_tap_sva u_sva (.*);
`default_nettype wire

// ---- verif/bst_jtag_host.sv ----
// Behavioural test controller
`default_nettype none
module bst_jtag_host (
  output logic tck, // test clock
  output logic tms, // mode select
  output logic tdi, // test data in
  output logic trst_n, // test reset
  input wire logic tdo, // test data
  input wire logic tdo_oe // its enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tck = 1'b0; // Stands low between frames
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // Drive while low, sample before the rise
  task automatic run(input logic [63:0] m, input logic [63:0] d, input int n,
    output logic [63:0] o);
    o = '0;
    for (int i = 0; i < n; i++)
    begin
      tms = m[i];
      tdi = d[i];
      #32;
      o[i] = tdo_oe ? tdo : ~tdo; // Released line reads inverted
      tck = 1'b1;
      #32;
      tck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_bst_tap.sv ----
// Self-checking bench for the scan port
`include "bst_params.svh"
`default_nettype none
module tb_bst_tap;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, tck, tms, tdi, trst_n, master_reset_n, oe_n;
  logic tdo, tdo_oe, q_oe, tap_reset_seen;
  logic [`BST_DATA_W-1:0] fifo_q, q_out;
  logic [63:0] o;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  bst_tap DUT (.*);
  bst_jtag_host host (.*);
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // From idle into a shift state, n bits, back to idle
  task automatic shift(input bit ir, input int n, input logic [63:0] d);
    int p;
    p = ir ? 4 : 3;
    host.run((ir ? 64'h3 : 64'h1) | (64'h3 << (p + n - 1)), d << p, p + n + 2, o);
    o = (o >> p) & ((64'h1 << n) - 64'h1);
  endtask
  task automatic t_core;
    @(posedge core_clk) oe_n <= 1'b0;
    host.run(64'h1f, 64'h0, 6, o);
    repeat (10) @(posedge core_clk);
    chk(q_oe, 1);
    chk(tap_reset_seen, 1);
    chk(q_out, fifo_q);
    oe_n <= 1'b1;
    master_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(q_oe, 0);
    chk(q_out, 0);
    master_reset_n <= 1'b1;
  endtask
  task automatic t_regs;
    shift(0, 32, 64'h0);
    chk(o, `BST_ID_VALUE);
    shift(1, 4, 64'hf);
    chk(o, `BST_IR_CAPTURE);
    shift(0, 8, 64'ha5);
    chk(o, 64'h4a);
  endtask
  task automatic t_trst;
    host.run(64'h1, 64'h0, 4, o);
    chk(tdo_oe, 1);
    host.trst_n = 1'b0; // Test reset driven on its own, not tied to master reset
    #1;
    chk(tdo_oe, 0);
    host.trst_n = 1'b1;
    host.run(64'h0, 64'h0, 1, o);
    shift(0, 32, 64'h0);
    chk(o, `BST_ID_VALUE);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    master_reset_n = 1'b1;
    oe_n = 1'b1;
    fifo_q = 36'h987654321;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_core();
    t_regs();
    t_trst();
    print_verdict();
  end
endmodule
`default_nettype wire
